//--- rtl/sbfe_crc32.sv
// Byte-wide running CRC-32 register
module sbfe_crc32 (
    input  wire logic        clk_sys_i,  // System clock
    input  wire logic        rst_n_i,    // Async reset, active low
    input  wire logic        init_i,     // Restart from the seed
    input  wire logic        en_i,       // Fold data_i in this cycle
    input  wire logic [7:0]  data_i,     // Byte to fold
    output logic      [31:0] crc_o       // Running remainder
);
    import sbfe_pkg::*;

    logic [31:0] base;

    // Init with en folds the first byte onto a fresh seed
    assign base = init_i ? CRC_INIT : crc_o;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            crc_o <= CRC_INIT;
        end else if (en_i) begin
            crc_o <= sbfe_crc_byte(base, data_i);
        end else if (init_i) begin
            crc_o <= CRC_INIT;
        end
    end

endmodule

//--- rtl/sbfe_framer.sv
// Sideband frame encapsulation on transmit and header and check sequence screening on receive
// Operation
// [RULE_01] Every packet wrapped: 14-byte header, 4-byte trailer
// [RULE_02] Control frames untagged; pass-through may carry tag
// [RULE_03] Far side sends header bytes big-endian
// [RULE_04] Valid standard pass-through frames are accepted
// [RULE_05] Bytes 0-5 carry destination, high byte first
// [RULE_06] Control frames use broadcast destination
// [RULE_07] Non-broadcast control frames are dropped
// [RULE_08] Bytes 6-11 carry source, never cause rejection
// [RULE_09] Own control frames use all-ones source
// [RULE_10] Bytes 12-13 type, control uses fixed type
// [RULE_11] Check sequence appended after last pad
// [RULE_12] Frames failing check sequence are discarded
// [RULE_13] Control payload 46..1500, frame 64..1518
// [RULE_14] Pass-through payload 42 tagged, 46 untagged, 1500 max
// [RULE_15] Check sequence is standard Ethernet CRC-32
module sbfe_framer (
    input  wire logic                clk_sys_i,       // System clock, 10 MHz
    input  wire logic                rst_n_i,         // Async reset, active low
    input  wire logic                tx_start_i,      // Frame start, fields below sampled
    input  wire logic                tx_ctrl_i,       // Frame is a control message
    input  wire logic                tx_vlan_i,       // Insert a VLAN tag, pass-through only
    input  wire logic [15:0]         tx_tci_i,        // VLAN tag control field
    input  wire logic [47:0]         tx_da_i,         // Pass-through destination
    input  wire logic [47:0]         tx_sa_i,         // Pass-through source
    input  wire logic [15:0]         tx_etype_i,      // Pass-through type
    input  wire logic                tx_valid_i,      // Payload byte valid
    input  wire logic [7:0]          tx_data_i,       // Payload byte
    input  wire logic                tx_last_i,       // Last payload byte
    output logic                     tx_ready_o,      // Payload byte taken
    output logic                     tx_busy_o,       // Frame in progress
    output logic                     lnk_tx_valid_o,  // Link byte valid
    output logic [7:0]               lnk_tx_data_o,   // Link byte
    output logic                     lnk_tx_last_o,   // Last check sequence byte
    input  wire logic                lnk_rx_valid_i,  // Received byte valid
    input  wire logic [7:0]          lnk_rx_data_i,   // Received byte
    input  wire logic                lnk_rx_last_i,   // Last received byte of frame
    output logic                     rx_valid_o,      // Frame byte out, trailer stripped
    output logic [7:0]               rx_data_o,       // Frame byte out
    output logic                     rx_done_o,       // Frame verdict pulse
    output logic                     rx_good_o,       // Verdict: keep the frame
    output logic                     rx_ctrl_o,       // Verdict: control message
    output logic                     rx_tagged_o      // Verdict: VLAN tagged
);
    import sbfe_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Transmit state
    sbfe_tx_e     tx_st_q;
    logic [143:0] hdr_q;
    sbfe_len_t    hdr_left_q;
    sbfe_len_t    pay_cnt_q;
    logic [1:0]   fcs_idx_q;
    logic         ctrl_q;
    logic         tag_q;
    logic         emit_en;
    logic [7:0]   emit_byte;
    logic         pay_end;
    sbfe_len_t    pay_min;
    logic [31:0]  crc_tx;
    logic [47:0]  hdr_da;
    logic [47:0]  hdr_sa;
    logic [15:0]  hdr_et;
    logic         hdr_tag;

    // Control frames override every address and type field the user gives
    assign hdr_da  = tx_ctrl_i ? BCAST_ADDR : tx_da_i;     // RULE_06
    assign hdr_sa  = tx_ctrl_i ? BCAST_ADDR : tx_sa_i;     // RULE_09
    assign hdr_et  = tx_ctrl_i ? CTRL_ETYPE : tx_etype_i;  // RULE_10
    assign hdr_tag = tx_vlan_i && !tx_ctrl_i;              // RULE_02

    always_comb begin
        emit_en   = 1'b0;
        emit_byte = 8'h00;
        unique case (tx_st_q)
            TX_IDLE: ;
            TX_HDR: begin
                emit_en   = 1'b1;
                emit_byte = hdr_q[143:136];
            end
            TX_PAY: begin
                emit_en   = tx_valid_i && tx_ready_o;
                emit_byte = tx_data_i;
            end
            TX_PAD: emit_en = 1'b1;
            TX_FCS: begin
                emit_en   = 1'b1;
                emit_byte = ~crc_tx[8 * fcs_idx_q +: 8];  // RULE_15
            end
            default: ;
        endcase
    end

    // Oversize payload is cut at the maximum; the user sees ready fall
    assign pay_end = (tx_st_q == TX_PAY) && emit_en
                     && (tx_last_i || pay_cnt_q == MAX_PAY - 11'h001);  // RULE_14
    assign pay_min = tag_q ? MIN_PAY_TAG : MIN_PAY_UNTAG;                // RULE_13 RULE_14

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_st_q    <= TX_IDLE;
            hdr_q      <= '0;
            hdr_left_q <= '0;
            pay_cnt_q  <= '0;
            fcs_idx_q  <= 2'h0;
            ctrl_q     <= 1'b0;
            tag_q      <= 1'b0;
            tx_ready_o <= 1'b0;
            tx_busy_o  <= 1'b0;
        end else begin
            unique case (tx_st_q)
                TX_IDLE: begin
                    if (tx_start_i) begin
                        ctrl_q    <= tx_ctrl_i;
                        tag_q     <= hdr_tag;
                        tx_busy_o <= 1'b1;
                        tx_st_q   <= TX_HDR;
                        // Fields go out most significant byte first
                        if (hdr_tag) begin
                            hdr_q      <= {hdr_da, hdr_sa, VLAN_TPID, tx_tci_i, hdr_et};  // RULE_02
                            hdr_left_q <= HDR_BYTES + VLAN_BYTES - 11'h001;
                        end else begin
                            hdr_q      <= {hdr_da, hdr_sa, hdr_et, 32'h0000_0000};        // RULE_05 RULE_08
                            hdr_left_q <= HDR_BYTES - 11'h001;                            // RULE_01
                        end
                    end
                end
                TX_HDR: begin
                    hdr_q      <= hdr_q << 8;
                    hdr_left_q <= hdr_left_q - 11'h001;
                    if (hdr_left_q == 11'h000) begin
                        tx_st_q    <= TX_PAY;
                        pay_cnt_q  <= '0;
                        tx_ready_o <= 1'b1;
                    end
                end
                TX_PAY: begin
                    if (emit_en) begin
                        pay_cnt_q <= pay_cnt_q + 11'h001;
                    end
                    if (pay_end) begin
                        tx_ready_o <= 1'b0;
                        fcs_idx_q  <= 2'h0;
                        tx_st_q    <= (pay_cnt_q + 11'h001 < pay_min) ? TX_PAD : TX_FCS;
                    end
                end
                TX_PAD: begin
                    pay_cnt_q <= pay_cnt_q + 11'h001;
                    if (pay_cnt_q == pay_min - 11'h001) begin
                        tx_st_q <= TX_FCS;
                    end
                end
                TX_FCS: begin
                    fcs_idx_q <= fcs_idx_q + 2'h1;
                    if (fcs_idx_q == 2'h3) begin
                        tx_st_q   <= TX_IDLE;
                        tx_busy_o <= 1'b0;
                    end
                end
                default: tx_st_q <= TX_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmit link output and check sequence
    // Trailer bytes are not folded in; the register must hold still while read out
    sbfe_crc32 u_crc_tx (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .init_i    (tx_st_q == TX_IDLE),
        .en_i      (emit_en && tx_st_q != TX_FCS),  // RULE_15
        .data_i    (emit_byte),
        .crc_o     (crc_tx)
    );

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lnk_tx_valid_o <= 1'b0;
            lnk_tx_data_o  <= 8'h00;
            lnk_tx_last_o  <= 1'b0;
        end else begin
            lnk_tx_valid_o <= emit_en;
            lnk_tx_data_o  <= emit_byte;
            lnk_tx_last_o  <= (tx_st_q == TX_FCS) && (fcs_idx_q == 2'h3);  // RULE_11
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receive header capture
    sbfe_len_t   rx_pos_q;
    sbfe_len_t   rx_len_q;
    logic        bcast_q;
    logic [15:0] etype_q;
    logic [15:0] inner_q;
    logic        eval_q;
    logic [31:0] crc_rx;
    logic [7:0]  dly_q [4];

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_pos_q <= '0;
            rx_len_q <= '0;
            bcast_q  <= 1'b0;
            etype_q  <= 16'h0000;
            inner_q  <= 16'h0000;
            eval_q   <= 1'b0;
        end else begin
            eval_q <= lnk_rx_valid_i && lnk_rx_last_i;
            if (lnk_rx_valid_i) begin
                rx_pos_q <= lnk_rx_last_i ? 11'h000 : sbfe_sat_inc(rx_pos_q);
                if (lnk_rx_last_i) begin
                    rx_len_q <= sbfe_sat_inc(rx_pos_q);
                end
                // Destination only tested for broadcast, never as a station address
                if (rx_pos_q == 11'h000) begin
                    bcast_q <= (lnk_rx_data_i == 8'hFF);                       // RULE_05
                end else if (rx_pos_q <= POS_DA_LAST) begin
                    bcast_q <= bcast_q && (lnk_rx_data_i == 8'hFF);
                end
                // Source bytes pass unchecked
                unique case (rx_pos_q)
                    POS_ETYPE_HI: etype_q[15:8] <= lnk_rx_data_i;              // RULE_03 RULE_10
                    POS_ETYPE_LO: etype_q[7:0]  <= lnk_rx_data_i;              // RULE_08
                    POS_INNER_HI: inner_q[15:8] <= lnk_rx_data_i;
                    POS_INNER_LO: inner_q[7:0]  <= lnk_rx_data_i;
                    default: ;
                endcase
            end
        end
    end

    sbfe_crc32 u_crc_rx (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .init_i    (lnk_rx_valid_i && rx_pos_q == 11'h000),
        .en_i      (lnk_rx_valid_i),
        .data_i    (lnk_rx_data_i),
        .crc_o     (crc_rx)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Receive delay line: holds back the trailer so it never reaches the user
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < 4; i++) begin
                dly_q[i] <= 8'h00;
            end
            rx_valid_o <= 1'b0;
            rx_data_o  <= 8'h00;
        end else begin
            rx_valid_o <= lnk_rx_valid_i && (rx_pos_q >= FCS_BYTES);
            if (lnk_rx_valid_i) begin
                rx_data_o <= dly_q[3];
                dly_q[0]  <= lnk_rx_data_i;
                for (int i = 1; i < 4; i++) begin
                    dly_q[i] <= dly_q[i - 1];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receive verdict
    logic      crc_ok;
    logic      rx_tag;
    logic      len_ok;
    logic      is_ctrl;
    logic      ctrl_ok;
    assign crc_ok  = (crc_rx == CRC_RESIDUE);                                     // RULE_12 RULE_15
    assign rx_tag  = (etype_q == VLAN_TPID);
    assign len_ok  = (rx_len_q >= MIN_FRAME)
                     && (rx_len_q <= (rx_tag ? MAX_FRAME_TAG : MAX_FRAME_UNTAG));   // RULE_13 RULE_14
    assign is_ctrl = (etype_q == CTRL_ETYPE) || (rx_tag && inner_q == CTRL_ETYPE);
    // A tagged control message, or one not sent to broadcast, is dropped
    assign ctrl_ok = !is_ctrl || (bcast_q && !rx_tag);                            // RULE_02 RULE_07

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_done_o   <= 1'b0;
            rx_good_o   <= 1'b0;
            rx_ctrl_o   <= 1'b0;
            rx_tagged_o <= 1'b0;
        end else begin
            rx_done_o <= eval_q;
            if (eval_q) begin
                rx_good_o   <= crc_ok && len_ok && ctrl_ok;                       // RULE_04 RULE_12
                rx_ctrl_o   <= is_ctrl;
                rx_tagged_o <= rx_tag;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    sbfe_len_t out_idx_q;
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            out_idx_q <= '0;
        end else if (lnk_tx_valid_o) begin
            out_idx_q <= lnk_tx_last_o ? 11'h000 : sbfe_sat_inc(out_idx_q);
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    a_ctrl_dest_bcast: assert property (lnk_tx_valid_o && ctrl_q && out_idx_q <= POS_DA_LAST  // RULE_06
        |-> lnk_tx_data_o == 8'hFF) else $error("control destination byte not all ones");
    a_ctrl_src_ones: assert property (lnk_tx_valid_o && ctrl_q && out_idx_q > POS_DA_LAST  // RULE_09
        && out_idx_q <= POS_SA_LAST |-> lnk_tx_data_o == 8'hFF) else $error("control source byte not all ones");
    a_ctrl_type_field: assert property (lnk_tx_valid_o && ctrl_q && out_idx_q == POS_ETYPE_HI  // RULE_10
        |-> lnk_tx_data_o == CTRL_ETYPE[15:8] ##1 lnk_tx_data_o == CTRL_ETYPE[7:0])
        else $error("control type field wrong");
    a_tag_tpid: assert property (lnk_tx_valid_o && tag_q && out_idx_q == POS_ETYPE_HI  // RULE_02
        |-> !ctrl_q && lnk_tx_data_o == VLAN_TPID[15:8] ##1 lnk_tx_data_o == VLAN_TPID[7:0])
        else $error("tag missing or on control frame");
    a_min_frame: assert property (lnk_tx_last_o |-> out_idx_q >= MIN_FRAME - 11'h001)  // RULE_13
        else $error("transmitted frame shorter than minimum");
    a_fcs_tail: assert property ($rose(tx_st_q == TX_FCS)  // RULE_11
        |-> (tx_st_q == TX_FCS)[*4] ##1 (tx_st_q == TX_IDLE && lnk_tx_last_o))
        else $error("trailer not four bytes ending the frame");
    a_rx_bad_fcs: assert property (eval_q && crc_rx != CRC_RESIDUE  // RULE_12
        |=> rx_done_o && !rx_good_o) else $error("bad check sequence frame kept");
    a_rx_ctrl_dest: assert property (eval_q && etype_q == CTRL_ETYPE && !bcast_q  // RULE_07
        |=> rx_done_o && !rx_good_o) else $error("non-broadcast control frame kept");
    a_rx_runt: assert property (eval_q && rx_len_q < MIN_FRAME  // RULE_13
        |=> rx_done_o && !rx_good_o) else $error("short frame kept");
    a_rx_pt_accept: assert property (eval_q && crc_ok && etype_q != CTRL_ETYPE && !rx_tag  // RULE_04
        && rx_len_q >= MIN_FRAME && rx_len_q <= MAX_FRAME_UNTAG |=> rx_done_o && rx_good_o)
        else $error("valid pass-through frame refused");

    c_tx_ctrl: cover property (lnk_tx_last_o && ctrl_q);
    c_tx_tagged: cover property (lnk_tx_last_o && tag_q);
    c_rx_good_ctrl: cover property (rx_done_o && rx_good_o && rx_ctrl_o);
    c_rx_drop: cover property (rx_done_o && !rx_good_o);

endmodule

//--- rtl/sbfe_pkg.sv
// Shared constants, types and CRC arithmetic for the sideband frame encapsulator
package sbfe_pkg;

    typedef logic [10:0] sbfe_len_t;

    // Header layout, byte positions counted from the first destination byte
    localparam sbfe_len_t   HDR_BYTES       = 11'h00E;
    localparam sbfe_len_t   VLAN_BYTES      = 11'h004;
    localparam sbfe_len_t   FCS_BYTES       = 11'h004;
    localparam sbfe_len_t   POS_DA_LAST     = 11'h005;
    localparam sbfe_len_t   POS_SA_LAST     = 11'h00B;
    localparam sbfe_len_t   POS_ETYPE_HI    = 11'h00C;
    localparam sbfe_len_t   POS_ETYPE_LO    = 11'h00D;
    localparam sbfe_len_t   POS_INNER_HI    = 11'h010;
    localparam sbfe_len_t   POS_INNER_LO    = 11'h011;

    // Field values
    localparam logic [47:0] BCAST_ADDR      = 48'hFFFF_FFFF_FFFF;
    localparam logic [15:0] CTRL_ETYPE      = 16'h88F8;
    localparam logic [15:0] VLAN_TPID       = 16'h8100;

    // Payload and frame size limits, frame sizes include the check sequence
    localparam sbfe_len_t   MIN_PAY_UNTAG   = 11'h02E;
    localparam sbfe_len_t   MIN_PAY_TAG     = 11'h02A;
    localparam sbfe_len_t   MAX_PAY         = 11'h5DC;
    localparam sbfe_len_t   MIN_FRAME       = 11'h040;
    localparam sbfe_len_t   MAX_FRAME_UNTAG = 11'h5EE;
    localparam sbfe_len_t   MAX_FRAME_TAG   = 11'h5F2;

    // Reflected CRC-32, residue seen after the check sequence itself is folded in
    localparam logic [31:0] CRC_POLY        = 32'hEDB8_8320;
    localparam logic [31:0] CRC_INIT        = 32'hFFFF_FFFF;
    localparam logic [31:0] CRC_RESIDUE     = 32'hDEBB_20E3;

    typedef enum logic [2:0] {
        TX_IDLE = 3'b000,
        TX_HDR  = 3'b001,
        TX_PAY  = 3'b011,
        TX_PAD  = 3'b010,
        TX_FCS  = 3'b110
    } sbfe_tx_e;

    function automatic logic [31:0] sbfe_crc_byte(input logic [31:0] crc, input logic [7:0] d);
        logic [31:0] c;
        c = crc ^ {24'h00_0000, d};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction

    // Byte counters stop at the top so oversize frames still read as oversize
    function automatic sbfe_len_t sbfe_sat_inc(input sbfe_len_t v);
        return (v == 11'h7FF) ? v : v + 11'h001;
    endfunction

endpackage

//--- verif/sbfe_framer_tb.sv
// Self-checking bench for the sideband frame encapsulator
module sbfe_framer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_sys_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        tx_start_i = 1'b0, tx_ctrl_i = 1'b0, tx_vlan_i = 1'b0;
    logic [15:0] tx_tci_i = 16'h6005, tx_etype_i = 16'h0800;
    logic [47:0] tx_da_i = 48'h0A1B_2C3D_4E5F, tx_sa_i = 48'h0211_2233_4455;
    logic        tx_valid_i = 1'b0, tx_last_i = 1'b0;
    logic [7:0]  tx_data_i = 8'h00;
    logic        tx_ready_o, tx_busy_o, lnk_tx_valid_o, lnk_tx_last_o;
    logic [7:0]  lnk_tx_data_o, lnk_rx_data_i, rx_data_o;
    logic        lnk_rx_valid_i, lnk_rx_last_i, rx_valid_o;
    logic        rx_done_o, rx_good_o, rx_ctrl_o, rx_tagged_o;
    int          failures = 0, total_checks = 0, cycles = 0, rx_n = 0;
    logic [7:0]  f_q[$];
    localparam logic [47:0] ONES = 48'hFFFF_FFFF_FFFF;

    always #50 clk_sys_i = ~clk_sys_i;

    sbfe_framer sbfe_framer_i (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .tx_start_i(tx_start_i), .tx_ctrl_i(tx_ctrl_i),
        .tx_vlan_i(tx_vlan_i), .tx_tci_i(tx_tci_i), .tx_da_i(tx_da_i), .tx_sa_i(tx_sa_i),
        .tx_etype_i(tx_etype_i), .tx_valid_i(tx_valid_i), .tx_data_i(tx_data_i), .tx_last_i(tx_last_i),
        .tx_ready_o(tx_ready_o), .tx_busy_o(tx_busy_o), .lnk_tx_valid_o(lnk_tx_valid_o),
        .lnk_tx_data_o(lnk_tx_data_o), .lnk_tx_last_o(lnk_tx_last_o), .lnk_rx_valid_i(lnk_rx_valid_i),
        .lnk_rx_data_i(lnk_rx_data_i), .lnk_rx_last_i(lnk_rx_last_i), .rx_valid_o(rx_valid_o),
        .rx_data_o(rx_data_o), .rx_done_o(rx_done_o), .rx_good_o(rx_good_o), .rx_ctrl_o(rx_ctrl_o),
        .rx_tagged_o(rx_tagged_o));

    sbfe_mc_model sbfe_mc_model_i (
        .clk_sys_i(clk_sys_i), .lnk_tx_valid_i(lnk_tx_valid_o), .lnk_tx_data_i(lnk_tx_data_o),
        .lnk_rx_valid_o(lnk_rx_valid_i), .lnk_rx_data_o(lnk_rx_data_i), .lnk_rx_last_o(lnk_rx_last_i));

    ////////////////////////////////////////////////////////////
    task automatic finish_test;
        if (failures == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic void put(input logic [47:0] v, input int n);
        for (int k = n - 1; k >= 0; k--) begin
            f_q.push_back(v[8*k +: 8]);
        end
    endfunction

    // Frame without trailer: header, payload pattern, zero pad to the minimum
    function automatic void build(input logic [47:0] da, input logic [47:0] sa, input logic tag,
                                  input logic [15:0] et, input int n);
        f_q.delete();
        put(da, 6);
        put(sa, 6);
        if (tag) begin
            put({32'h0000_0000, sbfe_pkg::VLAN_TPID}, 2);
            put({32'h0000_0000, tx_tci_i}, 2);
        end
        put({32'h0000_0000, et}, 2);
        for (int k = 0; k < n; k++) begin
            f_q.push_back(8'(k * 7 + 3));
        end
        while (f_q.size() < (tag ? 60 : 60)) begin
            f_q.push_back(8'h00);
        end
    endfunction

    ////////////////////////////////////////////////////////////
    task automatic tx_frame(input logic ctrl, input logic vlan, input int n);
        int i;
        logic [31:0] fcs;
        if (ctrl) begin
            build(ONES, ONES, 1'b0, sbfe_pkg::CTRL_ETYPE, n);
        end else begin
            build(tx_da_i, tx_sa_i, vlan, tx_etype_i, n);
        end
        fcs = sbfe_mc_model_i.crc_of(f_q);
        put({16'h0000, fcs[7:0], fcs[15:8], fcs[23:16], fcs[31:24]}, 4);
        sbfe_mc_model_i.cap_q.delete();
        tx_start_i <= 1'b1;
        tx_ctrl_i  <= ctrl;
        tx_vlan_i  <= vlan;
        @(posedge clk_sys_i);
        tx_start_i <= 1'b0;
        tx_valid_i <= 1'b1;
        tx_data_i  <= 8'h03;
        tx_last_i  <= (n == 1);
        i = 0;
        while (i < n) begin
            @(posedge clk_sys_i);
            if (tx_ready_o === 1'b1) begin
                i++;
                tx_data_i  <= 8'(i * 7 + 3);
                tx_last_i  <= (i == n - 1);
                tx_valid_i <= (i < n);
            end
        end
        // Padding can run 44 cycles; wait for the trailer, then one edge for the capture
        i = 0;
        while (tx_busy_o !== 1'b0 && i < 100) begin
            @(posedge clk_sys_i);
            i++;
        end
        @(posedge clk_sys_i);
        check({31'h0, tx_busy_o}, 32'h0000_0000);
        check(sbfe_mc_model_i.cap_q.size(), f_q.size());
        foreach (f_q[k]) begin
            check({24'h00_0000, sbfe_mc_model_i.cap_q[k]}, {24'h00_0000, f_q[k]});
        end
    endtask

    task automatic rx_frame(input logic bad, input logic [2:0] mask, input logic [2:0] exp);
        int i;
        rx_n = 0;
        sbfe_mc_model_i.send(f_q, bad);
        i = 0;
        while (rx_done_o !== 1'b1 && i < 10) begin
            @(posedge clk_sys_i);
            i++;
        end
        check({31'h0, rx_done_o}, 32'h0000_0001);
        check({29'h0, rx_good_o, rx_ctrl_o, rx_tagged_o} & {29'h0, mask}, {29'h0, exp});
        check(rx_n, f_q.size());
    endtask

    ////////////////////////////////////////////////////////////
    always @(posedge clk_sys_i) begin
        cycles++;
        if (rx_valid_o === 1'b1) begin
            check({24'h00_0000, rx_data_o}, {24'h00_0000, f_q[rx_n]});
            rx_n++;
        end
        if (cycles == 20000) begin
            failures++;
            finish_test;
        end
    end

    initial begin
        repeat (6) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        @(posedge clk_sys_i);
        check({30'h0, tx_busy_o, rx_done_o}, 32'h0000_0000);
        tx_frame(1'b1, 1'b1, 2);
        tx_frame(1'b0, 1'b1, 5);
        tx_frame(1'b0, 1'b0, 50);
        build(ONES, 48'h0F0E_0D0C_0B0A, 1'b0, sbfe_pkg::CTRL_ETYPE, 46);
        rx_frame(1'b0, 3'b111, 3'b110);
        build(tx_da_i, tx_sa_i, 1'b1, 16'h0800, 42);
        rx_frame(1'b0, 3'b111, 3'b101);
        build(tx_da_i, tx_sa_i, 1'b0, 16'h0800, 46);
        rx_frame(1'b1, 3'b100, 3'b000);
        build(tx_da_i, tx_sa_i, 1'b0, sbfe_pkg::CTRL_ETYPE, 46);
        rx_frame(1'b0, 3'b100, 3'b000);
        build(ONES, tx_sa_i, 1'b1, sbfe_pkg::CTRL_ETYPE, 42);
        rx_frame(1'b0, 3'b100, 3'b000);
        build(tx_da_i, tx_sa_i, 1'b0, 16'h0800, 46);
        rx_frame(1'b0, 3'b111, 3'b100);
        // Four bytes short of the minimum frame
        f_q = f_q[0:55];
        rx_frame(1'b0, 3'b100, 3'b000);
        finish_test;
    end
endmodule

//--- verif/sbfe_mc_model.sv
// Management controller model: frame source and sink on the link side
module sbfe_mc_model (
    input  wire logic       clk_sys_i,      // System clock
    input  wire logic       lnk_tx_valid_i, // Device byte valid
    input  wire logic [7:0] lnk_tx_data_i,  // Device byte
    output logic            lnk_rx_valid_o, // Byte to device valid
    output logic [7:0]      lnk_rx_data_o,  // Byte to device
    output logic            lnk_rx_last_o   // Last trailer byte
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] cap_q[$];

    initial begin
        lnk_rx_valid_o = 1'b0;
        lnk_rx_data_o  = 8'h00;
        lnk_rx_last_o  = 1'b0;
    end

    ////////////////////////////////////////////////////////////
    // Own copy of the reflected CRC, returned already inverted
    function automatic logic [31:0] crc_of(input logic [7:0] f[$]);
        logic [31:0] c;
        c = 32'hFFFF_FFFF;
        foreach (f[k]) begin
            c = c ^ {24'h00_0000, f[k]};
            for (int b = 0; b < 8; b++) begin
                c = c[0] ? ((c >> 1) ^ 32'hEDB8_8320) : (c >> 1);
            end
        end
        return ~c;
    endfunction

    // Header bytes arrive in the order the caller built them, high byte first
    task automatic send(input logic [7:0] f[$], input logic bad);
        logic [31:0] fcs;
        fcs = crc_of(f) ^ {31'h0000_0000, bad};
        for (int k = 0; k < 4; k++) begin
            f.push_back(fcs[8*k +: 8]);
        end
        foreach (f[k]) begin
            @(posedge clk_sys_i);
            lnk_rx_valid_o <= 1'b1;
            lnk_rx_data_o  <= f[k];
            lnk_rx_last_o  <= (k == f.size() - 1);
        end
        @(posedge clk_sys_i);
        lnk_rx_valid_o <= 1'b0;
        lnk_rx_last_o  <= 1'b0;
        // Released line shows junk, never the last byte
        lnk_rx_data_o  <= ~f[f.size() - 1];
    endtask

    ////////////////////////////////////////////////////////////
    always @(posedge clk_sys_i) begin
        if (lnk_tx_valid_i) begin
            cap_q.push_back(lnk_tx_data_i);
        end
    end
endmodule
